// ### alu_regs.vh
// Constants for the literal/file ALU datapath: opcodes, destination bits, reset values, nibble positions.
// Included by the datapath modules; holds definitions only.
`ifndef ALU_REGS_VH
`define ALU_REGS_VH

// Operation select codes
`define OP_NONE                   3'h0
`define OP_SUB_W_FROM_LITERAL     3'h1
`define OP_XOR_LITERAL_WITH_ACC   3'h2
`define OP_SUB_W_FROM_FILE        3'h3
`define OP_XOR_ACC_WITH_FILE      3'h4
`define OP_SWAP_FILE_NIBBLES      3'h5

// Destination bit values
`define DEST_ACC                  1'h0
`define DEST_FILE                 1'h1

// Reset values
`define ACC_RESET                 8'h00
`define FLAG_RESET                1'h0
`define BYTE_ZERO                 8'h00

// Nibble field positions
`define NIB_LO_MSB                3
`define NIB_HI_LSB                4

`endif

// ### alu_sub8.v
// Eight-bit subtractor giving result, carry (no borrow) and digit carry.
// Purely combinational; used by the datapath top.
`timescale 1ns/1ps
`include "alu_regs.vh"

module alu_sub8 #(
  parameter WIDTH = 8
) (
  // Operands
  input  wire [WIDTH-1:0] minuend_in,
  input  wire [WIDTH-1:0] subtrahend_in,
  // Results
  output wire [WIDTH-1:0] diff_out,
  output wire             carry_out,
  output wire             digit_carry_out
);

  wire [WIDTH:0] full_sum;
  wire [`NIB_HI_LSB:0] low_sum;

  // Two's complement subtract: a + ~b + 1, carry high means no borrow
  assign full_sum        = {1'b0, minuend_in} + {1'b0, ~subtrahend_in} + {{WIDTH{1'b0}}, 1'b1};
  assign low_sum         = {1'b0, minuend_in[`NIB_LO_MSB:0]} +
                           {1'b0, ~subtrahend_in[`NIB_LO_MSB:0]} + 5'h01;
  assign diff_out        = full_sum[WIDTH-1:0];
  assign carry_out       = full_sum[WIDTH];
  assign digit_carry_out = low_sum[`NIB_HI_LSB];

endmodule // alu_sub8

// ### literal_file_alu_ops.v
// Datapath for five byte operations: subtract and XOR against a literal or a
// file register, and file nibble swap. Holds the working register and flags.
// Assumes decoded opcode, literal, file data and destination come from core
// logic on the same clock, valid in the cycle op_valid_in is high.
//
// Summary of operation
// RULE_01 - Literal minus working register into working register; C, DC, Z updated.
// RULE_02 - Working register XOR literal into working register; only Z updated.
// RULE_03 - File register minus working register; C, DC, Z updated; address 0..127.
// RULE_04 - Working register XOR file register; only Z updated.
// RULE_05 - Swap file register nibbles; no status flag changes.
// RULE_06 - Register forms write working register when dest 0, file when 1.
// RULE_07 - Subtract carry/digit carry set on no borrow; zero set on zero result.
`timescale 1ns/1ps
`include "alu_regs.vh"

module literal_file_alu_ops #(
  parameter WIDTH = 8,
  parameter ADDR_W = 7
) (
  // Clock and reset
  input  wire              clk_in,
  input  wire              rst_b_in,
  // Decoded instruction
  input  wire              op_valid_in,
  input  wire [2:0]        op_sel_in,
  input  wire [WIDTH-1:0]  literal_in,
  input  wire [ADDR_W-1:0] file_addr_in,
  input  wire [WIDTH-1:0]  file_data_in,
  input  wire              dest_in,
  // File write-back
  output reg               file_wr_out,
  output reg  [ADDR_W-1:0] file_wr_addr_out,
  output reg  [WIDTH-1:0]  file_wr_data_out,
  // Architectural state
  output reg  [WIDTH-1:0]  acc_out,
  output reg               carry_flag_out,
  output reg               digit_carry_flag_out,
  output reg               zero_flag_out
);

  // Timing: an operation is taken at the rising edge on which op_valid_in
  // is high and completes at that same edge. W, the flags and the write
  // strobe all change there, so the next operation already sees the new W.
  // Fetching the file operand is the core's job: file_data_in must carry
  // the addressed register in the same cycle as the opcode.
  // A file write issued here reaches the file one cycle later, so a
  // back-to-back operation on the same address needs forwarding in the core.
  // Unused op_sel_in codes, and op_valid_in low, leave all state untouched
  // and keep the write strobe low.
  // The subtractor sits on the W output directly; W must not be written
  // elsewhere in the same cycle, or the subtract would see a stale value.
  // Literal forms ignore dest_in entirely.

  // Decode results
  reg  [WIDTH-1:0]  result_next;
  reg               use_file_dest;
  reg               write_acc;
  reg               upd_cz;
  reg               upd_z;

  // Subtractor operand and results
  reg  [WIDTH-1:0]  sub_a;
  wire [WIDTH-1:0]  diff;
  wire              sub_c;
  wire              sub_dc;

  // Qualified state-change enables
  wire              acc_wr_en;
  wire              file_wr_en;
  wire              flag_cz_en;
  wire              flag_z_en;

  // Zero detect used by several operations
  function is_zero;
    input [WIDTH-1:0] val;
    begin
      is_zero = (val == {WIDTH{1'b0}});
    end
  endfunction

  // Exchange the two nibbles of a byte
  function [WIDTH-1:0] swap_nibbles;
    input [WIDTH-1:0] val;
    begin
      swap_nibbles = {val[`NIB_LO_MSB:0], val[WIDTH-1:`NIB_HI_LSB]};
    end
  endfunction

  // Bitwise exclusive-OR of the working register with a second operand
  function [WIDTH-1:0] xor_bytes;
    input [WIDTH-1:0] a;
    input [WIDTH-1:0] b;
    begin
      xor_bytes = a ^ b;
    end
  endfunction

  // Shared subtractor: minuend is literal or file, subtrahend is W
  // One subtractor serves both subtract forms; only the minuend mux differs,
  // which keeps the carry and digit-carry logic identical for both.
  alu_sub8 #(
    .WIDTH           (WIDTH)
  ) u_sub (
    .minuend_in      (sub_a),
    .subtrahend_in   (acc_out),
    .diff_out        (diff),
    .carry_out       (sub_c),
    .digit_carry_out (sub_dc)
  );

  // Opcode map on op_sel_in:
  //   1        literal minus W, to W
  //   2        W xor literal, to W
  //   3        file minus W, to destination
  //   4        W xor file, to destination
  //   5        file nibbles swapped, to destination
  //   0, 6, 7  no operation

  // Operation decode and result select
  always @* begin
    sub_a         = file_data_in;
    result_next   = `BYTE_ZERO;
    use_file_dest = 1'b0;
    write_acc     = 1'b0;
    upd_cz        = 1'b0;
    upd_z         = 1'b0;
    case (op_sel_in)
      `OP_SUB_W_FROM_LITERAL: begin
        // RULE_01 literal minus W
        sub_a       = literal_in;
        result_next = diff;
        write_acc   = 1'b1;
        upd_cz      = 1'b1;
      end
      `OP_XOR_LITERAL_WITH_ACC: begin
        // RULE_02 literal XOR, Z only
        result_next = xor_bytes(acc_out, literal_in);
        write_acc   = 1'b1;
        upd_z       = 1'b1;
      end
      `OP_SUB_W_FROM_FILE: begin
        // RULE_03 file minus W
        result_next   = diff;
        use_file_dest = 1'b1;
        upd_cz        = 1'b1;
      end
      `OP_XOR_ACC_WITH_FILE: begin
        // RULE_04 file XOR, Z only
        result_next   = xor_bytes(acc_out, file_data_in);
        use_file_dest = 1'b1;
        upd_z         = 1'b1;
      end
      `OP_SWAP_FILE_NIBBLES: begin
        // RULE_05 nibble exchange, flags held
        result_next   = swap_nibbles(file_data_in);
        use_file_dest = 1'b1;
      end
      default: begin
        result_next = `BYTE_ZERO;
      end
    endcase
  end

  // Qualify decode with op_valid_in; refused codes leave everything alone
  // RULE_06 destination decode
  assign acc_wr_en  = op_valid_in && (write_acc || (use_file_dest && dest_in == `DEST_ACC));
  assign file_wr_en = op_valid_in && use_file_dest && (dest_in == `DEST_FILE);
  // RULE_07 flag update enables
  assign flag_cz_en = op_valid_in && upd_cz;
  assign flag_z_en  = op_valid_in && (upd_cz || upd_z);

  // Working register: literal forms always, register forms when dest is 0
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      acc_out <= `ACC_RESET;
    end else begin
      // RULE_06 destination select
      if (acc_wr_en) begin
        acc_out <= result_next;
      end
    end
  end

  // Status flags: carry and digit carry from subtracts, zero from all but swap
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      carry_flag_out       <= `FLAG_RESET;
      digit_carry_flag_out <= `FLAG_RESET;
      zero_flag_out        <= `FLAG_RESET;
    end else begin
      // RULE_07 carry means no borrow
      if (flag_cz_en) begin
        carry_flag_out       <= sub_c;
        digit_carry_flag_out <= sub_dc;
      end
      // RULE_07 zero on zero result
      if (flag_z_en) begin
        zero_flag_out <= is_zero(result_next);
      end
    end
  end

  // File write-back: one-cycle strobe, address and data hold until next write
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      file_wr_out      <= 1'b0;
      file_wr_addr_out <= {ADDR_W{1'b0}};
      file_wr_data_out <= `BYTE_ZERO;
    end else begin
      file_wr_out <= file_wr_en;
      // RULE_06 file destination
      if (file_wr_en) begin
        file_wr_addr_out <= file_addr_in;
        file_wr_data_out <= result_next;
      end
    end
  end

endmodule // literal_file_alu_ops

// ### alu_ops_monitor.sv
// Port checker for the literal/file ALU datapath.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module alu_ops_monitor #(parameter WIDTH = 8, parameter ADDR_W = 7) (
  input wire clk_in, rst_b_in, op_valid_in, dest_in, file_wr_out,
  input wire [2:0] op_sel_in,
  input wire [WIDTH-1:0] literal_in, file_data_in, acc_out, file_wr_data_out,
  input wire [ADDR_W-1:0] file_addr_in, file_wr_addr_out,
  input wire carry_flag_out, digit_carry_flag_out, zero_flag_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // Expected results and borrows
  wire [WIDTH-1:0] dl = literal_in - acc_out;
  wire [WIDTH-1:0] df = file_data_in - acc_out;
  wire [WIDTH-1:0] xf = file_data_in ^ acc_out;
  wire [WIDTH-1:0] sw = {file_data_in[3:0], file_data_in[7:4]};
  wire lit = op_sel_in == 3'h1;
  wire cy = (lit ? literal_in : file_data_in) >= acc_out;
  wire dc = (lit ? literal_in[3:0] : file_data_in[3:0]) >= acc_out[3:0];
  wire sub = op_valid_in && (lit || op_sel_in == 3'h3);
  wire rop = op_valid_in && op_sel_in >= 3'h3 && op_sel_in <= 3'h5;
  AST_SUB_LIT: assert property (op_valid_in && lit |=> acc_out == $past(dl))
    else $error("literal subtract result wrong");
  AST_XOR_LIT: assert property (op_valid_in && op_sel_in == 3'h2 |=>
    acc_out == ($past(acc_out) ^ $past(literal_in)) && $stable(carry_flag_out))
    else $error("literal xor wrong");
  AST_SUB_FILE: assert property (rop && op_sel_in == 3'h3 && dest_in |=>
    file_wr_data_out == $past(df) && file_wr_addr_out == $past(file_addr_in))
    else $error("file subtract wrong");
  AST_XOR_FILE: assert property (rop && op_sel_in == 3'h4 |=>
    zero_flag_out == ($past(xf) == 8'h00) && $stable(digit_carry_flag_out))
    else $error("file xor flags wrong");
  AST_SWAP: assert property (rop && op_sel_in == 3'h5 |=>
    $stable({carry_flag_out, digit_carry_flag_out, zero_flag_out}) &&
    ($past(dest_in) ? file_wr_data_out : acc_out) == $past(sw)) else $error("swap wrong");
  AST_DEST: assert property (rop |=> file_wr_out == $past(dest_in))
    else $error("destination wrong");
  AST_SUB_FLAGS: assert property (sub |=> carry_flag_out == $past(cy) &&
    digit_carry_flag_out == $past(dc)) else $error("subtract flags wrong");
  AST_NO_WRITE: assert property (!rop |=> !file_wr_out)
    else $error("file write without register op");
  AST_HOLD: assert property (!op_valid_in |=> $stable(acc_out))
    else $error("working register changed without op");
  // Main scenarios reached
  cover property (sub && !cy);
  cover property (rop && op_sel_in == 3'h5 && dest_in);
  cover property (rop && op_sel_in == 3'h4 && !dest_in);
endmodule // alu_ops_monitor
bind literal_file_alu_ops alu_ops_monitor #(.WIDTH(WIDTH), .ADDR_W(ADDR_W)) mon (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .op_valid_in(op_valid_in), .dest_in(dest_in),
  .file_wr_out(file_wr_out), .op_sel_in(op_sel_in), .literal_in(literal_in),
  .file_data_in(file_data_in), .acc_out(acc_out), .file_wr_data_out(file_wr_data_out),
  .file_addr_in(file_addr_in), .file_wr_addr_out(file_wr_addr_out),
  .carry_flag_out(carry_flag_out), .digit_carry_flag_out(digit_carry_flag_out),
  .zero_flag_out(zero_flag_out));

// ### literal_file_alu_ops_test.sv
// Self-checking bench for the literal/file ALU datapath.
// Assumes a 4 ns clock; inputs change on the falling edge.
`timescale 1ns/1ps
module literal_file_alu_ops_test;
  reg clk_in = 0, rst_b_in = 0, op_valid_in = 0, dest_in = 0;
  reg [2:0] op_sel_in = 0;
  reg [7:0] literal_in = 0, file_data_in = 0, acc, r;
  reg [6:0] file_addr_in = 0;
  reg c, dc, z, wr;
  integer num_errors = 0, compares = 0, seed = 95, i;
  wire [7:0] acc_out, file_wr_data_out;
  wire [6:0] file_wr_addr_out;
  wire file_wr_out, carry_flag_out, digit_carry_flag_out, zero_flag_out;
  literal_file_alu_ops uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .op_valid_in(op_valid_in),
    .op_sel_in(op_sel_in), .literal_in(literal_in), .file_addr_in(file_addr_in),
    .file_data_in(file_data_in), .dest_in(dest_in), .file_wr_out(file_wr_out),
    .file_wr_addr_out(file_wr_addr_out), .file_wr_data_out(file_wr_data_out),
    .acc_out(acc_out), .carry_flag_out(carry_flag_out),
    .digit_carry_flag_out(digit_carry_flag_out), .zero_flag_out(zero_flag_out));
  initial forever #2 clk_in = ~clk_in;
  task chk(input string n, input [7:0] e, input [7:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  // Apply one operation, update the expected state, compare after the edge
  task step(input [2:0] s, input [7:0] l, input [7:0] f, input d, input v);
    op_sel_in = s; literal_in = l; file_data_in = f; dest_in = d; op_valid_in = v;
    file_addr_in = $random(seed);
    if (!v) s = 0;
    wr = 0;
    r = s == 1 ? l - acc : s == 2 ? l ^ acc : s == 3 ? f - acc : s == 4 ? f ^ acc : {f[3:0], f[7:4]};
    if (s == 1 || s == 3) begin
      c = (s == 1 ? l : f) >= acc;
      dc = (s == 1 ? l[3:0] : f[3:0]) >= acc[3:0];
    end
    if (s >= 1 && s <= 4) z = r == 0;
    if (s >= 3 && s <= 5 && d) wr = 1;
    else if (s >= 1 && s <= 5) acc = r;
    @(negedge clk_in);
    chk("acc", acc, acc_out);
    chk("flags", {c, dc, z}, {carry_flag_out, digit_carry_flag_out, zero_flag_out});
    chk("wr", wr, file_wr_out);
    if (wr) chk("wdata", r, file_wr_data_out);
    if (wr) chk("waddr", file_addr_in, file_wr_addr_out);
  endtask
  task results;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #4000;
    num_errors++;
    results;
  end
  initial begin
    {acc, c, dc, z} = 0;
    repeat (2) @(negedge clk_in);
    chk("reset acc", 8'h00, acc_out);
    chk("reset flags", 8'h00, {file_wr_out, carry_flag_out, digit_carry_flag_out, zero_flag_out});
    rst_b_in = 1;
    step(1, 8'h00, 8'h00, 1, 1);
    step(3, 8'h00, 8'h10, 1, 1);
    step(1, 8'h01, 8'h00, 0, 1);
    step(5, 8'h00, 8'hA5, 0, 1);
    step(2, 8'hFF, 8'hFF, 0, 0);
    for (i = 1; i < 6; i++) step(i, 8'h3C, 8'hC3, 1, 1);
    $display("test directed done");
    rst_b_in = 0;
    op_valid_in = 0;
    {acc, c, dc, z} = 0;
    @(negedge clk_in);
    chk("reset acc", 8'h00, acc_out);
    chk("reset flags", 8'h00, {file_wr_out, carry_flag_out, digit_carry_flag_out, zero_flag_out});
    chk("reset wdata", 8'h00, file_wr_data_out);
    rst_b_in = 1;
    $display("test reset done");
    for (i = 0; i < 300; i++) step($random(seed), $random(seed), $random(seed), $random(seed), ($random(seed) & 7) != 0);
    $display("test random done");
    results;
  end
endmodule // literal_file_alu_ops_test
